// ===== hdl/switch_pkg.sv
// constants, address map and priorities for the six-port master/slave switch
package switch_pkg;
  localparam int unsigned NUM_PORTS  = 6;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ID_W       = 3;
  localparam int unsigned PRIO_W     = 2;
  localparam int unsigned REGION_MSB = 31;
  localparam int unsigned REGION_LSB = 28;

  // master port indices
  localparam int unsigned M_IFETCH0 = 0;
  localparam int unsigned M_IFETCH1 = 1;
  localparam int unsigned M_DATA0   = 2;
  localparam int unsigned M_DATA1   = 3;
  localparam int unsigned M_DMA     = 4;
  localparam int unsigned M_COMM    = 5;

  // slave port indices
  localparam int unsigned S_CODE_FLASH = 0;
  localparam int unsigned S_DATA_FLASH = 1;
  localparam int unsigned S_SRAM48     = 2;
  localparam int unsigned S_SRAM32     = 3;
  localparam int unsigned S_BRIDGE0    = 4;
  localparam int unsigned S_BRIDGE1    = 5;

  // address region (addr[31:28]) decoded to each slave, index 0 in the low nibble
  localparam logic [NUM_PORTS-1:0][3:0] SLAVE_REGION = {4'hd, 4'hc, 4'h5, 4'h4, 4'h1, 4'h0};
  localparam logic [NUM_PORTS-1:0][3:0] SRAM_KB      = {4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  localparam int unsigned SRAM48_KB = 48;
  localparam int unsigned SRAM32_KB = 32;

  // fixed priority per master port, master 0 in the low field; higher wins
  localparam logic [NUM_PORTS-1:0][PRIO_W-1:0] MASTER_PRIO = {2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
  localparam logic [PRIO_W-1:0] ELEVATED_PRIO = 2'h3;

  localparam logic [ID_W-1:0]      LAST_RESET  = 3'h0;
  localparam logic [NUM_PORTS-1:0] OWNER_RESET = 6'h00;
endpackage : switch_pkg

// ===== hdl/arb_if.sv
// request, grant-enable and ownership signals between the switch and one slave arbiter
`timescale 1ns/1ps
`default_nettype none
interface arb_if;
  logic [switch_pkg::NUM_PORTS-1:0] req;    // masters addressing this slave
  logic [switch_pkg::NUM_PORTS-1:0] allow;  // masters that may win a new grant now
  logic [switch_pkg::NUM_PORTS-1:0] elev;   // priority elevation per master
  logic [switch_pkg::NUM_PORTS-1:0] owner;  // one-hot current owner
  logic                             busy;   // slave is owned

  modport arb (input req, input allow, input elev, output owner, output busy);
  modport ctl (output req, output allow, output elev, input owner, input busy);
endinterface : arb_if
`default_nettype wire

// ===== hdl/slave_arbiter.sv
// per-slave arbiter: fixed priority, elevation, round robin among equals, held ownership
`timescale 1ns/1ps
`default_nettype none
module slave_arbiter (
  input  wire logic i_clk,   // system clock
  input  wire logic i_rstn,  // async reset, active low
  arb_if.arb        port     // requests in, owner out
);
  localparam int unsigned N = switch_pkg::NUM_PORTS;

  logic [N-1:0]                      owner_q;
  logic [N-1:0]                      owner_d;
  logic [switch_pkg::ID_W-1:0]       last_q;
  logic [switch_pkg::ID_W-1:0]       last_d;
  logic [N-1:0]                      win;
  logic [switch_pkg::ID_W-1:0]       win_id;
  logic [N-1:0][switch_pkg::PRIO_W-1:0] eff;
  logic [switch_pkg::PRIO_W-1:0]     best;
  logic                              cand;
  logic                              found;
  logic [switch_pkg::ID_W-1:0]       idx;

  // elevated masters outrank every fixed level
  always_comb begin
    for (int m = 0; m < N; m++) begin
      eff[m] = port.elev[m] ? switch_pkg::ELEVATED_PRIO : switch_pkg::MASTER_PRIO[m]; // RL7 RL8 RL11
    end
  end

  always_comb begin
    best   = '0;
    cand   = 1'b0;
    win    = '0;
    win_id = last_q;
    found  = 1'b0;
    idx    = '0;
    for (int m = 0; m < N; m++) begin
      if (port.req[m] && port.allow[m] && (!cand || eff[m] > best)) begin
        best = eff[m]; // RL4
        cand = 1'b1;
      end
    end
    // rotate from the master after the last one granted
    for (int k = 1; k <= N; k++) begin
      idx = ID_W_CAST((int'(last_q) + k) % N); // RL6
      if (!found && port.req[idx] && port.allow[idx] && eff[idx] == best) begin
        win[idx] = 1'b1;
        win_id   = idx;
        found    = 1'b1;
      end
    end
  end

  function automatic logic [switch_pkg::ID_W-1:0] ID_W_CAST(input int v);
    ID_W_CAST = v[switch_pkg::ID_W-1:0];
  endfunction : ID_W_CAST

  wire owner_holds = |(owner_q & port.req);

  // owner keeps the slave until it drops its request; losers wait
  assign owner_d = owner_holds ? owner_q : win; // RL5
  assign last_d  = (!owner_holds && found) ? win_id : last_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      owner_q <= switch_pkg::OWNER_RESET;
      last_q  <= switch_pkg::LAST_RESET; // RL12
    end else begin
      owner_q <= owner_d;
      last_q  <= last_d;
    end
  end

  assign port.owner = owner_q;
  assign port.busy  = |owner_q;
endmodule : slave_arbiter
`default_nettype wire

// ===== hdl/master_slave_switch.sv
// six-master by six-slave switch with per-slave arbitration and a two-transfer limit
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RL1] six master and six slave ports; distinct pairs connect at once.
// [RL2] 32-bit address and data pass unchanged between connected master and slave.
// [RL3] at most two transfers active; if two, one is an instruction fetch to code flash.
// [RL4] contending masters on one slave: highest priority requester wins.
// [RL5] losing masters stall until the owner finishes its transfers to that slave.
// [RL6] equal priority requesters are granted round robin after the last granted id.
// [RL7] default priority is a fixed value per master port.
// [RL8] a master's priority can be raised temporarily, then falls back.
// [RL9] masters: two fetch ports, two load/store ports, DMA, communication controller.
// [RL10] slaves: code and data flash, 48 KB and 32 KB SRAM, two peripheral bridges.
// [RL11] per-master elevation input makes it top priority; round robin among elevated.
// [RL12] after reset each slave's last granted pointer is master zero.
module master_slave_switch (
  input  wire logic                   i_clk,       // system clock
  input  wire logic                   i_rstn,      // async reset, active low
  input  wire logic [5:0]             i_m_req,     // master transfer request, held to end
  input  wire logic [5:0][31:0]       i_m_addr,    // master address
  input  wire logic [5:0]             i_m_we,      // master write enable
  input  wire logic [5:0][31:0]       i_m_wdata,   // master write data
  input  wire logic [5:0]             i_m_elev,    // master priority elevation
  output logic      [5:0]             o_m_ready,   // beat accepted or answered
  output logic      [5:0]             o_m_err,     // unmapped address answer
  output logic      [5:0][31:0]       o_m_rdata,   // read data to master
  output logic      [5:0]             o_s_req,     // request to slave
  output logic      [5:0][31:0]       o_s_addr,    // address to slave
  output logic      [5:0]             o_s_we,      // write enable to slave
  output logic      [5:0][31:0]       o_s_wdata,   // write data to slave
  output logic      [5:0][2:0]        o_s_master,  // id of owning master
  input  wire logic [5:0]             i_s_ready,   // slave beat done
  input  wire logic [5:0][31:0]       i_s_rdata    // read data from slave
);
  localparam int unsigned N = switch_pkg::NUM_PORTS;

  logic [N-1:0][N-1:0] hit;       // hit[m][s]
  logic [N-1:0][N-1:0] req_ms;    // req_ms[s][m]
  logic [N-1:0][N-1:0] owner;     // owner[s][m]
  logic [N-1:0]        busy;
  logic [N-1:0][N-1:0] is_fetch;  // is_fetch[s][m]
  logic [N-1:0]        nf_pending;
  logic [N-1:0]        token_ok;
  logic                nf_busy;

  arb_if arb [N] ();

  // address decode: each master selects at most one slave
  always_comb begin
    for (int m = 0; m < N; m++) begin
      for (int s = 0; s < N; s++) begin
        hit[m][s] = i_m_addr[m][switch_pkg::REGION_MSB:switch_pkg::REGION_LSB]
                    == switch_pkg::SLAVE_REGION[s]; // RL10
      end
    end
  end

  // a fetch is an instruction port addressing code flash
  always_comb begin
    for (int s = 0; s < N; s++) begin
      for (int m = 0; m < N; m++) begin
        req_ms[s][m]   = i_m_req[m] & hit[m][s]; // RL1
        is_fetch[s][m] = (s == switch_pkg::S_CODE_FLASH)
                         && (m == switch_pkg::M_IFETCH0 || m == switch_pkg::M_IFETCH1); // RL9
      end
    end
  end

  // one non-fetch connection at a time, lowest slave index takes the free slot
  always_comb begin
    nf_busy = 1'b0;
    for (int s = 0; s < N; s++) begin
      // an owner that has dropped its request frees the slot at this same edge
      nf_busy       = nf_busy | (busy[s] & |(owner[s] & req_ms[s] & ~is_fetch[s])); // RL3
      nf_pending[s] = ~(busy[s] & |(owner[s] & req_ms[s])) & |(req_ms[s] & ~is_fetch[s]);
    end
    for (int s = 0; s < N; s++) begin
      token_ok[s] = ~nf_busy;
      for (int j = 0; j < s; j++) begin
        if (nf_pending[j]) begin
          token_ok[s] = 1'b0; // RL3
        end
      end
    end
  end

  genvar gs;
  generate
    for (gs = 0; gs < N; gs++) begin : g_slave
      assign arb[gs].req   = req_ms[gs];
      assign arb[gs].allow = is_fetch[gs] | (token_ok[gs] ? {N{1'b1}} : {N{1'b0}}); // RL3
      assign arb[gs].elev  = i_m_elev; // RL8 RL11
      assign owner[gs]     = arb[gs].owner;
      assign busy[gs]      = arb[gs].busy;

      slave_arbiter u_arb (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .port   (arb[gs])
      );
    end
  endgenerate

  // slave side: owner's signals pass through unchanged
  always_comb begin
    for (int s = 0; s < N; s++) begin
      o_s_req[s]    = 1'b0;
      o_s_addr[s]   = '0;
      o_s_we[s]     = 1'b0;
      o_s_wdata[s]  = '0;
      o_s_master[s] = '0;
      for (int m = 0; m < N; m++) begin
        if (owner[s][m]) begin
          o_s_req[s]    = req_ms[s][m]; // RL1
          o_s_addr[s]   = i_m_addr[m];  // RL2
          o_s_we[s]     = i_m_we[m];
          o_s_wdata[s]  = i_m_wdata[m]; // RL2
          o_s_master[s] = 3'(m);
        end
      end
    end
  end

  // master side: only the owner or an unmapped requester sees ready; others stall
  always_comb begin
    for (int m = 0; m < N; m++) begin
      o_m_ready[m] = 1'b0;
      o_m_rdata[m] = '0;
      o_m_err[m]   = i_m_req[m] & ~|hit[m];
      for (int s = 0; s < N; s++) begin
        if (owner[s][m] && hit[m][s]) begin
          o_m_ready[m] = i_s_ready[s]; // RL5
          o_m_rdata[m] = i_s_rdata[s]; // RL2
        end
      end
      if (o_m_err[m]) begin
        o_m_ready[m] = 1'b1;
      end
    end
  end
endmodule : master_slave_switch
`default_nettype wire

// ===== bench/switch_props.sv
// port assertions for the master/slave switch
`timescale 1ns/1ps
`default_nettype none
module switch_props (
  input wire logic             i_clk,      // clock
  input wire logic             i_rstn,     // reset
  input wire logic [5:0]       i_m_req,    // requests
  input wire logic [5:0][31:0] i_m_addr,   // addresses
  input wire logic [5:0]       i_s_ready,  // slave ready
  input wire logic [5:0][31:0] i_s_rdata,  // slave data
  input wire logic [5:0]       o_m_ready,  // master ready
  input wire logic [5:0]       o_m_err,    // unmapped
  input wire logic [5:0][31:0] o_m_rdata,  // master data
  input wire logic [5:0]       o_s_req,    // slave request
  input wire logic [5:0][31:0] o_s_addr,   // slave address
  input wire logic [5:0][2:0]  o_s_master  // owner id
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic [5:0] served;
  always_comb begin
    served = 6'h00;
    for (int s = 0; s < 6; s++) if (o_s_req[s]) served[o_s_master[s]] = 1'b1;
  end
  a_two_max: assert property ($countones(o_s_req) <= 2) else $error("too many transfers");
  a_two_fetch: assert property ($countones(o_s_req) == 2 |-> o_s_req[0] && o_s_master[0] <= 3'h1)
    else $error("second transfer not a fetch");
  for (genvar s = 0; s < 6; s++) begin : g_s
    sequence held;
      o_s_req[s] ##1 i_m_req[$past(o_s_master[s])];
    endsequence
    a_owner_req: assert property (o_s_req[s] |-> i_m_req[o_s_master[s]]) else $error("no owner request");
    a_addr_pass: assert property (o_s_req[s] |-> o_s_addr[s] == i_m_addr[o_s_master[s]])
      else $error("address altered");
    a_read_back: assert property (o_s_req[s] && i_s_ready[s] |-> o_m_ready[o_s_master[s]] &&
      o_m_rdata[o_s_master[s]] == i_s_rdata[s]) else $error("read data lost");
    a_owner_holds: assert property (held |-> o_s_master[s] == $past(o_s_master[s]))
      else $error("ownership taken early");
  end
  for (genvar m = 0; m < 6; m++) begin : g_m
    a_loser_stalls: assert property (i_m_req[m] && !o_m_err[m] && !served[m] |-> !o_m_ready[m])
      else $error("loser not stalled");
    a_err_answers: assert property (o_m_err[m] |-> o_m_ready[m] && !served[m]) else $error("unmapped hang");
  end
endmodule : switch_props
bind master_slave_switch switch_props u_switch_props (.i_clk(i_clk), .i_rstn(i_rstn), .i_m_req(i_m_req),
  .i_m_addr(i_m_addr), .i_s_ready(i_s_ready), .i_s_rdata(i_s_rdata), .o_m_ready(o_m_ready), .o_m_err(o_m_err),
  .o_m_rdata(o_m_rdata), .o_s_req(o_s_req), .o_s_addr(o_s_addr), .o_s_master(o_s_master));
`default_nettype wire

// ===== bench/slave_model.sv
// six behavioural slaves; data from address, stall mask, junk when idle
`timescale 1ns/1ps
`default_nettype none
module slave_model (
  input  wire logic             i_clk,   // clock
  input  wire logic [5:0]       i_req,   // request per slave
  input  wire logic [5:0][31:0] i_addr,  // address per slave
  input  wire logic [5:0]       i_hold,  // stall mask
  output logic      [5:0]       o_ready, // beat done
  output logic      [5:0][31:0] o_rdata  // read data
);
  logic [31:0] junk_q = 32'h0;
  always_ff @(posedge i_clk) begin
    junk_q <= junk_q + 32'h1;
  end
  always_comb begin
    for (int s = 0; s < 6; s++) begin
      o_ready[s] = i_req[s] & ~i_hold[s];
      o_rdata[s] = i_req[s] ? ~i_addr[s] : junk_q;
    end
  end
endmodule : slave_model
`default_nettype wire

// ===== bench/test_master_slave_switch.sv
// self-checking bench for the master/slave switch
`timescale 1ns/1ps
`default_nettype none
module test_master_slave_switch;
  logic             clk = 1'b0;
  logic             rstn;
  logic [5:0]       m_req, m_we, m_elev, hold, m_ready, m_err, s_req, s_we, s_ready;
  logic [5:0][31:0] m_addr, m_wdata, m_rdata, s_addr, s_wdata, s_rdata;
  logic [5:0][2:0]  s_master;
  int               failures = 0;
  int               n_compared = 0;
  always #5 clk = ~clk;
  master_slave_switch u_master_slave_switch (.i_clk(clk), .i_rstn(rstn), .i_m_req(m_req), .i_m_addr(m_addr),
    .i_m_we(m_we), .i_m_wdata(m_wdata), .i_m_elev(m_elev), .o_m_ready(m_ready), .o_m_err(m_err),
    .o_m_rdata(m_rdata), .o_s_req(s_req), .o_s_addr(s_addr), .o_s_we(s_we), .o_s_wdata(s_wdata),
    .o_s_master(s_master), .i_s_ready(s_ready), .i_s_rdata(s_rdata));
  slave_model u_slave_model (.i_clk(clk), .i_req(s_req), .i_addr(s_addr), .i_hold(hold), .o_ready(s_ready),
    .o_rdata(s_rdata));
  task automatic tick;
    @(negedge clk);
  endtask : tick
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic ask(input int m, input logic [31:0] a);
    m_req[m]  = 1'b1;
    m_addr[m] = a;
  endtask : ask
  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic t_single;
    ask(2, 32'h4000_0010);
    m_we[2]    = 1'b1;
    m_wdata[2] = 32'h1234_abcd;
    tick;
    chk("owner", 32'h2, s_master[2]);
    chk("addr", 32'h4000_0010, s_addr[2]);
    chk("wdata", 32'h1234_abcd, s_wdata[2]);
    chk("we", 32'h1, s_we[2]);
    chk("rdata", 32'hbfff_ffef, m_rdata[2]);
    repeat (2) tick;
    chk("held owner", 32'h2, s_master[2]);
    chk("held ready", 32'h1, m_ready[2]);
    m_req = 6'h00;
    m_we  = 6'h00;
    tick;
    chk("release", 32'h0, s_req[2]);
  endtask : t_single
  task automatic t_priority;
    ask(5, 32'hc000_0000);
    ask(2, 32'hc000_0004);
    hold[4] = 1'b1;
    tick;
    chk("prio owner", 32'h2, s_master[4]);
    chk("slow", 32'h0, m_ready[2]);
    chk("stall", 32'h0, m_ready[5]);
    hold[4]  = 1'b0;
    m_req[2] = 1'b0;
    tick;
    chk("next owner", 32'h5, s_master[4]);
    chk("served", 32'h1, m_ready[5]);
    m_req = 6'h00;
    tick;
  endtask : t_priority
  task automatic t_rr;
    logic [31:0] order [4] = '{32'h2, 32'h3, 32'h4, 32'h2};
    m_addr[4:2] = {3{32'h5000_0020}};
    m_req[4:2]  = 3'b111;
    for (int i = 0; i < 4; i++) begin
      tick;
      chk("rr owner", order[i], s_master[3]);
      m_req[4:2] = ~(3'b001 << (order[i] - 2));
    end
    tick;
    m_req = 6'h00;
    tick;
  endtask : t_rr
  task automatic t_elev;
    m_elev[5] = 1'b1;
    ask(5, 32'hd000_0000);
    ask(2, 32'hd000_0008);
    tick;
    chk("elevated", 32'h5, s_master[5]);
    m_req  = 6'h00;
    m_elev = 6'h00;
    tick;
    m_req = 6'h24;
    tick;
    chk("fixed", 32'h2, s_master[5]);
    m_req = 6'h00;
    tick;
  endtask : t_elev
  task automatic t_limit;
    ask(0, 32'h0000_0100);
    ask(2, 32'h4000_0000);
    ask(3, 32'hc000_0000);
    ask(4, 32'h8000_0000);
    tick;
    chk("fetch", 32'h1, s_req[0]);
    chk("pair", 32'h1, s_req[2]);
    chk("third", 32'h0, s_req[4]);
    chk("third stall", 32'h0, m_ready[3]);
    chk("unmapped", 32'h3, {m_err[4], m_ready[4]});
    tick;
    chk("pair held", 32'h0, s_req[4]);
    m_req[2] = 1'b0;
    tick;
    chk("third owner", 32'h3, s_master[4]);
    m_req = 6'h00;
    tick;
  endtask : t_limit
  initial begin
    {rstn, m_req, m_we, m_elev, hold} = '0;
    m_addr  = '0;
    m_wdata = '0;
    repeat (5) tick;
    rstn = 1'b1;
    tick;
    t_single;
    t_priority;
    t_rr;
    t_elev;
    t_limit;
    wrap_up;
  end
  initial begin
    repeat (500) @(posedge clk);
    failures++;
    wrap_up;
  end
endmodule : test_master_slave_switch
`default_nettype wire
